// file: test_vinest_top.sv
// bench for the nesting block: wishbone register tasks and source scenarios
// assumes one 250 MHz clock and the source model beside the block
`timescale 1ns/1ps
module test_vinest_top;
  import vinest_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [31:0] wb_adr_i = 32'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0] wb_sel_i = 4'h0;
  logic wb_we_i = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic [31:0] want = 32'h0;
  logic [31:0] wb_dat_o, src_i, rdat;
  logic wb_ack_o, wb_err_o, normal_irq_o, fast_irq_o, event_irq_o, rerr;
  int bad_count = 0;
  int n_compared = 0;
  int cycles = 0;
  vinest_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .src_i(src_i),
    .normal_irq_o(normal_irq_o), .fast_irq_o(fast_irq_o), .event_irq_o(event_irq_o));
  vinest_src_model src_u (.clk_i(clk_i), .want_i(want), .src_o(src_i));
  initial begin
    forever #2 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      close_out();
    end
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic close_out();
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic bus(input logic [31:0] adr, input logic we, input logic [31:0] dat);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_adr_i <= adr;
    wb_we_i <= we;
    wb_dat_i <= dat;
    wb_sel_i <= 4'hf;
    do @(posedge clk_i);
    while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
    rdat = wb_dat_o;
    rerr = wb_err_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : bus
  task automatic rdc(input logic [31:0] adr, input logic [31:0] exp);
    bus(adr, 1'b0, 32'h0);
    chk(rdat, exp);
  endtask : rdc
  task automatic idle(input int k);
    repeat (k) @(posedge clk_i);
  endtask : idle
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    rdc(VINEST_ADR_NEST_CTRL, 32'h0);
    rdc(VINEST_ADR_NORMAL_STACK, 32'h0);
    rdc(VINEST_ADR_FAST_STACK, 32'h0);
    rdc(VINEST_ADR_FAST_VECTOR, 32'h0);
    bus(32'hffff0100, 1'b0, 32'h0);
    chk({31'h0, rerr}, 32'h1);
  endtask : t_reset
  task automatic t_prio();
    bus(VINEST_ADR_PRIO_THIRD, 1'b1, 32'hffffffff);
    rdc(VINEST_ADR_PRIO_THIRD, 32'h00777777);
    bus(VINEST_ADR_PRIO_THIRD, 1'b1, 32'h00020013);
  endtask : t_prio
  task automatic t_flat();
    bus(VINEST_ADR_NORMAL_ENABLE, 1'b1, 32'h00030000);
    want <= 32'h00130000;
    idle(6);
    chk({31'h0, normal_irq_o}, 32'h1);
    rdc(VINEST_ADR_NORMAL_VECTOR, 32'h40);
    rdc(VINEST_ADR_NORMAL_STACK, 32'h0);
    bus(VINEST_ADR_FAST_ENABLE, 1'b1, 32'h00100000);
    idle(3);
    chk({30'h0, fast_irq_o, normal_irq_o}, 32'h2);
    bus(VINEST_ADR_VEC_BASE, 1'b1, 32'h1234);
    rdc(VINEST_ADR_FAST_VECTOR, 32'h00091a50);
    rdc(VINEST_ADR_FAST_STACK, 32'h0);
  endtask : t_flat
  task automatic t_nest();
    bus(VINEST_ADR_FAST_ENABLE, 1'b1, 32'h0);
    bus(VINEST_ADR_NEST_CTRL, 1'b1, 32'h3);
    want <= 32'h00010000;
    idle(6);
    rdc(VINEST_ADR_NORMAL_VECTOR, 32'h00091a40);
    rdc(VINEST_ADR_NORMAL_STACK, 32'h08);
    idle(3);
    chk({31'h0, normal_irq_o}, 32'h0);
    want <= 32'h00030000;
    idle(6);
    chk({31'h0, normal_irq_o}, 32'h1);
    rdc(VINEST_ADR_NORMAL_VECTOR, 32'h00091a44);
    rdc(VINEST_ADR_NORMAL_STACK, 32'h0a);
    bus(VINEST_ADR_INT_ENABLE, 1'b1, 32'h4);
    bus(VINEST_ADR_NORMAL_STACK, 1'b1, 32'hff);
    rdc(VINEST_ADR_NORMAL_STACK, 32'h08);
    idle(3);
    chk({31'h0, event_irq_o}, 32'h1);
    bus(VINEST_ADR_INT_STATUS, 1'b0, 32'h0);
    chk(rdat & 32'h4, 32'h4);
    chk(rdat, 32'h7);
    bus(VINEST_ADR_INT_CLEAR, 1'b1, 32'h4);
    idle(3);
    chk({31'h0, event_irq_o}, 32'h0);
    bus(VINEST_ADR_NORMAL_STACK, 1'b1, 32'hff);
    rdc(VINEST_ADR_NORMAL_STACK, 32'h0);
  endtask : t_nest
  task automatic t_fast();
    bus(VINEST_ADR_FAST_ENABLE, 1'b1, 32'h00100000);
    want <= 32'h00100000;
    idle(6);
    chk({31'h0, fast_irq_o}, 32'h1);
    rdc(VINEST_ADR_FAST_VECTOR, 32'h00091a50);
    rdc(VINEST_ADR_FAST_STACK, 32'h04);
    idle(3);
    chk({31'h0, fast_irq_o}, 32'h0);
    bus(VINEST_ADR_FAST_STACK, 1'b1, 32'h0);
    rdc(VINEST_ADR_FAST_STACK, 32'h0);
    idle(4);
    chk({31'h0, fast_irq_o}, 32'h1);
  endtask : t_fast
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_prio();
    t_flat();
    t_nest();
    t_fast();
    close_out();
  end
endmodule : test_vinest_top
bind vinest_top vinest_top_sva chk_u (.clk_i, .rst_i, .wb_adr_i, .wb_we_i, .wb_cyc_i,
  .wb_stb_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .normal_irq_o, .fast_irq_o);

// file: vinest_pkg.sv
// package for the vectored interrupt nesting block: register map, field layout, constants
// assumes a 32-bit classic wishbone slave port and up to 32 interrupt sources
package vinest_pkg;
  // ----------------------------------------
  // register byte addresses
  // ----------------------------------------
  localparam logic [31:0] VINEST_ADR_NEST_CTRL = 32'hffff0030;
  localparam logic [31:0] VINEST_ADR_NORMAL_STACK = 32'hffff003c;
  localparam logic [31:0] VINEST_ADR_FAST_VECTOR = 32'hffff011c;
  localparam logic [31:0] VINEST_ADR_FAST_STACK = 32'hffff013c;
  localparam logic [31:0] VINEST_ADR_PRIO_THIRD = 32'hffff0028;
  localparam logic [31:0] VINEST_ADR_VEC_BASE = 32'hffff0014;
  localparam logic [31:0] VINEST_ADR_NORMAL_VECTOR = 32'hffff001c;
  localparam logic [31:0] VINEST_ADR_NORMAL_ENABLE = 32'hffff0040;
  localparam logic [31:0] VINEST_ADR_FAST_ENABLE = 32'hffff0044;
  localparam logic [31:0] VINEST_ADR_INT_STATUS = 32'hffff0048;
  localparam logic [31:0] VINEST_ADR_INT_ENABLE = 32'hffff004c;
  localparam logic [31:0] VINEST_ADR_INT_CLEAR = 32'hffff0050;
  localparam logic [31:0] VINEST_ADR_PRIO_OTHER = 32'hffff0054;
  // ----------------------------------------
  // field layout
  // ----------------------------------------
  localparam int VINEST_NSRC = 32;
  localparam int VINEST_NLVL = 8;
  localparam int VINEST_NORMAL_NSRC = 22;
  localparam int VINEST_FAST_NSRC = 28;
  localparam int VINEST_NORMAL_NEST_BIT = 0;
  localparam int VINEST_FAST_NEST_BIT = 1;
  localparam int VINEST_VEC_BASE_LSB = 7;
  localparam int VINEST_VEC_SRC_LSB = 2;
  localparam int VINEST_NUM_PRIO3 = 6;
  // third priority register: field lsb and the source number it serves
  localparam logic [4:0] VINEST_P3_LSB [VINEST_NUM_PRIO3] = '{5'd20, 5'd16, 5'd12, 5'd8, 5'd4, 5'd0};
  localparam logic [4:0] VINEST_P3_SRC [VINEST_NUM_PRIO3] = '{5'd21, 5'd20, 5'd19, 5'd18, 5'd17, 5'd16};
  localparam logic [31:0] VINEST_PRIO3_MASK = 32'h00777777;
  // ----------------------------------------
  // reset values and event bits
  // ----------------------------------------
  localparam logic [1:0] VINEST_NEST_RESET = 2'h0;
  localparam logic [7:0] VINEST_STACK_RESET = 8'h00;
  localparam int VINEST_EV_NORMAL_REQ = 0;
  localparam int VINEST_EV_FAST_REQ = 1;
  localparam int VINEST_EV_STACK_POP = 2;
  localparam int VINEST_NEV = 3;
endpackage : vinest_pkg

// file: vinest_sel_if.sv
// interface between the top block and the priority selector
// assumes both ends run on one clock
`timescale 1ns/1ps
interface vinest_sel_if;
  logic [31:0] pend;
  logic [95:0] lvl;
  logic [7:0] stack;
  logic nest_en;
  logic hit;
  logic [4:0] src;
  logic [2:0] src_lvl;
  modport req (output pend, output lvl, output stack, output nest_en, input hit, input src,
    input src_lvl);
  modport sel (input pend, input lvl, input stack, input nest_en, output hit, output src,
    output src_lvl);
endinterface : vinest_sel_if

// file: vinest_select.sv
// priority selector: picks the winning source of one interrupt class
// assumes pend already holds only enabled sources of that class
`timescale 1ns/1ps
module vinest_select (
  vinest_sel_if.sel s
);
  import vinest_pkg::*;
  always_comb begin
    logic [3:0] best;
    best = 4'h8;
    s.hit = 1'b0;
    s.src = 5'h00;
    s.src_lvl = 3'h0;
    for (int i = 0; i < VINEST_NSRC; i++) begin
      logic [2:0] l;
      logic ok;
      // with nesting off all levels count as equal
      l = s.nest_en ? s.lvl[i*3 +: 3] : 3'h0;
      // a set stack bit blocks its level and all less urgent ones
      ok = s.nest_en ? ((s.stack & ((8'h02 << l) - 8'h01)) == 8'h00) : 1'b1;
      // strictly lower level wins; ties keep the lowest source number
      if (s.pend[i] && ok && {1'b0, l} < best) begin
        best = {1'b0, l};
        s.hit = 1'b1;
        s.src = 5'(i);
        s.src_lvl = l;
      end
    end
  end
endmodule : vinest_select

// file: vinest_src_model.sv
// peripheral source model: request lines into the nesting block
// assumes the bench gives the wanted levels; lines move only after a clock edge
`timescale 1ns/1ps
module vinest_src_model (
  input wire logic clk_i,
  input wire logic [31:0] want_i,
  output logic [31:0] src_o
);
  always_ff @(posedge clk_i) begin
    src_o <= want_i;
  end
endmodule : vinest_src_model

// file: vinest_top.sv
// vectored interrupt nesting and prioritisation with a wishbone register port
// assumes synchronous sources on clk_i; sources 22 to 27 are fast-only, sources 28 to 31 reach neither class
`timescale 1ns/1ps
module vinest_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  input wire logic [vinest_pkg::VINEST_NSRC-1:0] src_i,
  output logic normal_irq_o,
  output logic fast_irq_o,
  output logic event_irq_o
);
  import vinest_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [31:0] src_s1;
    logic [31:0] src_s2;
    logic [1:0] nest;
    logic [31:0] prio3;
    logic [63:0] prio_other;
    logic [15:0] base;
    logic [31:0] normal_en;
    logic [31:0] fast_en;
    logic [7:0] normal_stack;
    logic [7:0] fast_stack;
    logic [VINEST_NEV-1:0] ev_status;
    logic [VINEST_NEV-1:0] ev_enable;
    logic normal_prev;
    logic fast_prev;
    logic [31:0] rdata;
    logic ack;
    logic err;
    logic normal_irq;
    logic fast_irq;
    logic ev_irq;
  } vinest_state_t;

  vinest_state_t st;
  vinest_state_t next_st;

  // ----------------------------------------
  // level table and selectors
  // ----------------------------------------
  logic [95:0] lvl_all;
  vinest_sel_if nsel ();
  vinest_sel_if fsel ();

  // other sources take 3-bit levels from prio_other at source mod 21; sources 22 to 31 share the fields of 1 to 10
  genvar g;
  generate
    for (g = 0; g < VINEST_NSRC; g++) begin : g_lvl
      if (g >= 16 && g <= 21) begin : g_p3
        assign lvl_all[g*3 +: 3] = st.prio3[VINEST_P3_LSB[21-g] +: 3];
      end else begin : g_po
        assign lvl_all[g*3 +: 3] = st.prio_other[(g % 21) * 3 +: 3];
      end
    end
  endgenerate

  assign nsel.pend = st.src_s2 & st.normal_en & 32'h003fffff;
  assign nsel.lvl = lvl_all;
  assign nsel.stack = st.normal_stack;
  assign nsel.nest_en = st.nest[VINEST_NORMAL_NEST_BIT];
  assign fsel.pend = st.src_s2 & st.fast_en & 32'h0fffffff;
  assign fsel.lvl = lvl_all;
  assign fsel.stack = st.fast_stack;
  assign fsel.nest_en = st.nest[VINEST_FAST_NEST_BIT];

  vinest_select u_normal_sel (
    .s(nsel)
  );
  vinest_select u_fast_sel (
    .s(fsel)
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [7:0] pop_urgent(input logic [7:0] v);
    logic [7:0] r;
    r = v;
    for (int i = VINEST_NLVL - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = v & ~(8'h01 << i);
      end
    end
    return r;
  endfunction : pop_urgent

  function automatic logic [31:0] vec_word(input logic [15:0] b, input logic [4:0] s);
    return {9'h000, b, s, 2'h0};
  endfunction : vec_word

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
    input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic req;
    logic rd;
    logic wr;
    logic [VINEST_NEV-1:0] ev_set;
    logic [31:0] a;
    logic normal_now;
    logic fast_now;
    next_st = st;
    req = wb_cyc_i && wb_stb_i && !st.ack && !st.err;
    rd = req && !wb_we_i;
    wr = req && wb_we_i;
    a = wb_adr_i;
    ev_set = '0;
    next_st.src_s1 = src_i;
    next_st.src_s2 = st.src_s1;
    next_st.ack = 1'b0;
    next_st.err = 1'b0;
    next_st.rdata = 32'h00000000;
    if (req) begin
      next_st.ack = 1'b1;
      if (a == VINEST_ADR_NEST_CTRL) begin
        next_st.rdata = {30'h0, st.nest};
        if (wr) begin
          next_st.nest = wb_sel_i[0] ? wb_dat_i[1:0] : st.nest;
        end
      end else if (a == VINEST_ADR_PRIO_THIRD) begin
        next_st.rdata = st.prio3;
        if (wr) begin
          next_st.prio3 = merge(st.prio3, wb_dat_i, wb_sel_i) & VINEST_PRIO3_MASK;
        end
      end else if (a == VINEST_ADR_PRIO_OTHER) begin
        next_st.rdata = st.prio_other[31:0];
        if (wr) begin
          next_st.prio_other[31:0] = merge(st.prio_other[31:0], wb_dat_i, wb_sel_i);
        end
      end else if (a == VINEST_ADR_VEC_BASE) begin
        next_st.rdata = {16'h0, st.base};
        if (wr) begin
          next_st.base = 16'(merge({16'h0, st.base}, wb_dat_i, wb_sel_i));
        end
      end else if (a == VINEST_ADR_NORMAL_VECTOR) begin
        next_st.rdata = vec_word(st.base, nsel.src);
        if (rd && st.nest[VINEST_NORMAL_NEST_BIT] && nsel.hit) begin
          next_st.normal_stack[nsel.src_lvl] = 1'b1;
        end
      end else if (a == VINEST_ADR_FAST_VECTOR) begin
        next_st.rdata = vec_word(st.base, fsel.src);
        if (rd && st.nest[VINEST_FAST_NEST_BIT] && fsel.hit) begin
          next_st.fast_stack[fsel.src_lvl] = 1'b1;
        end
      end else if (a == VINEST_ADR_NORMAL_STACK) begin
        next_st.rdata = {24'h0, st.normal_stack};
        if (wr) begin
          next_st.normal_stack = pop_urgent(st.normal_stack);
          ev_set[VINEST_EV_STACK_POP] = 1'b1;
        end
      end else if (a == VINEST_ADR_FAST_STACK) begin
        next_st.rdata = {24'h0, st.fast_stack};
        if (wr) begin
          next_st.fast_stack = pop_urgent(st.fast_stack);
          ev_set[VINEST_EV_STACK_POP] = 1'b1;
        end
      end else if (a == VINEST_ADR_NORMAL_ENABLE) begin
        next_st.rdata = st.normal_en;
        if (wr) begin
          next_st.normal_en = merge(st.normal_en, wb_dat_i, wb_sel_i);
        end
      end else if (a == VINEST_ADR_FAST_ENABLE) begin
        next_st.rdata = st.fast_en;
        if (wr) begin
          next_st.fast_en = merge(st.fast_en, wb_dat_i, wb_sel_i);
        end
      end else if (a == VINEST_ADR_INT_STATUS) begin
        next_st.rdata = {29'h0, st.ev_status};
      end else if (a == VINEST_ADR_INT_ENABLE) begin
        next_st.rdata = {29'h0, st.ev_enable};
        if (wr && wb_sel_i[0]) begin
          next_st.ev_enable = wb_dat_i[VINEST_NEV-1:0];
        end
      end else if (a == VINEST_ADR_INT_CLEAR) begin
        if (wr && wb_sel_i[0]) begin
          next_st.ev_status = st.ev_status & ~wb_dat_i[VINEST_NEV-1:0];
        end
      end else begin
        next_st.ack = 1'b0;
        next_st.err = 1'b1;
      end
    end
    // fast request outranks normal: normal line is held off while fast pends
    fast_now = fsel.hit;
    normal_now = nsel.hit && !fsel.hit;
    next_st.fast_irq = fast_now;
    next_st.normal_irq = normal_now;
    next_st.fast_prev = fast_now;
    next_st.normal_prev = normal_now;
    ev_set[VINEST_EV_NORMAL_REQ] = normal_now && !st.normal_prev;
    ev_set[VINEST_EV_FAST_REQ] = fast_now && !st.fast_prev;
    // a new event wins over a clear in the same cycle
    next_st.ev_status = next_st.ev_status | ev_set;
    next_st.ev_irq = |(next_st.ev_status & next_st.ev_enable);
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
      st.nest <= VINEST_NEST_RESET;
      st.normal_stack <= VINEST_STACK_RESET;
      st.fast_stack <= VINEST_STACK_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign wb_dat_o = st.rdata;
  assign wb_ack_o = st.ack;
  assign wb_err_o = st.err;
  assign normal_irq_o = st.normal_irq;
  assign fast_irq_o = st.fast_irq;
  assign event_irq_o = st.ev_irq;
endmodule : vinest_top

// file: vinest_top_sva.sv
// checker for the nesting block: bus answer timing and register read layout
// assumes it is bound to vinest_top and that the master holds a request until ack
`timescale 1ns/1ps
module vinest_top_sva
  import vinest_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  input wire logic normal_irq_o,
  input wire logic fast_irq_o
);
  // ----------------------------------------
  // bus answers, read layout and irq outputs
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic rd;
  assign rd = wb_ack_o && !wb_we_i;
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  a_answer_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o
    |=> wb_ack_o || wb_err_o) else $error("request not answered next cycle");
  a_ack_err_excl: assert property (!(wb_ack_o && wb_err_o)) else $error("ack and err together");
  a_idle_data: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data without ack");
  a_ctrl_upper: assert property (rd && wb_adr_i == VINEST_ADR_NEST_CTRL
    |-> wb_dat_o[31:2] == 30'h0) else $error("control upper bits set");
  a_stack_width: assert property (rd && (wb_adr_i == VINEST_ADR_NORMAL_STACK
    || wb_adr_i == VINEST_ADR_FAST_STACK) |-> wb_dat_o[31:8] == 24'h0) else $error("stack wide");
  a_fast_layout: assert property (rd && wb_adr_i == VINEST_ADR_FAST_VECTOR
    |-> wb_dat_o[31:23] == 9'h0 && wb_dat_o[1:0] == 2'h0 && wb_dat_o[6:2] < 5'd28)
    else $error("fast vector layout");
  a_normal_layout: assert property (rd && wb_adr_i == VINEST_ADR_NORMAL_VECTOR
    |-> wb_dat_o[31:23] == 9'h0 && wb_dat_o[1:0] == 2'h0 && wb_dat_o[6:2] < 5'd22)
    else $error("normal vector layout");
  a_prio_fields: assert property (rd && wb_adr_i == VINEST_ADR_PRIO_THIRD
    |-> (wb_dat_o & ~VINEST_PRIO3_MASK) == 32'h0) else $error("priority reserved bits set");
  a_fast_first: assert property (fast_irq_o |-> !normal_irq_o)
    else $error("normal raised beside fast");
  c_err: cover property (wb_err_o);
  c_fast: cover property (fast_irq_o);
  c_pop: cover property (wb_ack_o && wb_we_i && wb_adr_i == VINEST_ADR_NORMAL_STACK);
endmodule : vinest_top_sva
